// ---- src/scp_synth_ctrl.sv ----
// Operation
// - The power byte drives the amplifier level, 0x00 lowest, 0xFF highest.
// - Auto-calibration runs at synthesizer turn-on or at automatic turn-off.
// - A calibrate strobe in idle starts a manual calibration.
// - Calibration results survive every power-down mode.
// - A full calibration lasts 735 us at 26 MHz or 796 us at 24 MHz.
// - The three result registers are read-write; turn-on takes 75 or 81 us.
// - One VCO current and one charge pump result serve all frequencies.
// - Zero in bits 5:4 of the charge pump result skips its calibration.
// - With it skipped and mode 01, receive or transmit runs VCO cal only.
// - Without charge pump calibration a run lasts 168 or 182 us.
// - The idle strobe always forces the controller to idle.
//
// Local design decisions: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
module scp_synth_ctrl
  import scp_pkg::*;
#(
  parameter int FULL_26   = CAL_FULL_26_CYC,
  parameter int FULL_24   = CAL_FULL_24_CYC,
  parameter int SHORT_26  = CAL_SHORT_26_CYC,
  parameter int SHORT_24  = CAL_SHORT_24_CYC,
  parameter int TURNON_26 = TURNON_26_CYC,
  parameter int TURNON_24 = TURNON_24_CYC
) (
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic [1:0]        power_down_mode,
  input  wire logic              synth_auto_off,
  input  wire logic [7:0]        meas_cp_cal,
  input  wire logic [7:0]        meas_vco_current,
  input  wire logic [7:0]        meas_vco_cap,
  output logic [7:0]             pa_power_setting,
  output logic [7:0]             charge_pump_cal_result,
  output logic [7:0]             vco_current_cal_result,
  output logic [7:0]             vco_cap_cal_result,
  output logic                   synth_on,
  output logic                   synth_cal_active,
  output logic                   radio_rx_on,
  output logic                   radio_tx_on,
  output logic                   radio_idle
);

  // ****************************************************************
  // Register bus.
  // ****************************************************************
  logic              wr_en;
  logic [ADDR_W-1:0] wr_addr;
  logic [31:0]       wr_data;
  logic [3:0]        wr_strb;
  logic              wr_hit;
  logic [ADDR_W-1:0] rd_addr;
  logic [31:0]       rd_data;
  logic              rd_hit;

  scp_axil_slave u_bus (
    .clk           (clk),
    .rst_n         (rst_n),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .wr_en         (wr_en),
    .wr_addr       (wr_addr),
    .wr_data       (wr_data),
    .wr_strb       (wr_strb),
    .wr_hit        (wr_hit),
    .rd_addr       (rd_addr),
    .rd_data       (rd_data),
    .rd_hit        (rd_hit)
  );

  logic [7:0]  cfg_reg;
  scp_state_t  state_reg;
  scp_state_t  state_next;
  logic        target_tx_reg;
  logic [CNT_W-1:0] settle_cnt_reg;
  logic        wr_lane0;
  logic        stb_cal;
  logic        stb_rx;
  logic        stb_tx;
  logic        stb_idle;
  logic [1:0]  autocal;
  logic        ref_24m;
  logic        cp_en;
  logic        cal_start;
  logic        cal_abort;
  logic        cal_busy;
  logic        cal_done;

  // Address decode; only the low byte lane carries register data.
  assign wr_hit   = (wr_addr == OFS_PA) || (wr_addr == OFS_CFG) ||
                    (wr_addr == OFS_STROBE) || (wr_addr == OFS_CP) ||
                    (wr_addr == OFS_VCUR) || (wr_addr == OFS_VCAP) ||
                    (wr_addr == OFS_STAT);
  assign wr_lane0 = wr_en && wr_strb[0];
  assign stb_cal  = wr_lane0 && (wr_addr == OFS_STROBE) && wr_data[STB_CAL];
  assign stb_rx   = wr_lane0 && (wr_addr == OFS_STROBE) && wr_data[STB_RX];
  assign stb_tx   = wr_lane0 && (wr_addr == OFS_STROBE) && wr_data[STB_TX];
  assign stb_idle = wr_lane0 && (wr_addr == OFS_STROBE) &&
                    wr_data[STB_IDLE];
  assign autocal  = cfg_reg[AUTOCAL_LSB +: 2];
  assign ref_24m  = cfg_reg[REF24_BIT];
  assign cp_en    = (charge_pump_cal_result[CP_EN_LSB +: 2] != 2'h0);

  // Read multiplexer; strobe register reads zero, status shows state.
  always_comb begin
    rd_data = 32'h0000_0000;
    rd_hit  = 1'b1;
    case (rd_addr)
      OFS_PA:     rd_data[7:0] = pa_power_setting;
      OFS_CFG:    rd_data[7:0] = cfg_reg;
      OFS_STROBE: rd_data[7:0] = 8'h00;
      OFS_CP:     rd_data[7:0] = charge_pump_cal_result;
      OFS_VCUR:   rd_data[7:0] = vco_current_cal_result;
      OFS_VCAP:   rd_data[7:0] = vco_cap_cal_result;
      OFS_STAT:   rd_data[7:0] = {4'h0, cal_busy, 3'(state_reg)};
      default:    rd_hit = 1'b0;
    endcase
  end

  // ****************************************************************
  // Software settings.
  // ****************************************************************

  // Power byte goes straight to the amplifier level control.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pa_power_setting <= PA_RST;
    end else if (wr_lane0 && (wr_addr == OFS_PA)) begin
      pa_power_setting <= wr_data[7:0];
    end
  end

  // Auto-calibration select and reference frequency select.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_reg <= CFG_RST;
    end else if (wr_lane0 && (wr_addr == OFS_CFG)) begin
      cfg_reg <= wr_data[7:0];
    end
  end

  // ****************************************************************
  // Calibration results.
  // ****************************************************************

  // Results change only by software or by a finished calibration, never
  // by power-down, and a finishing calibration wins over a write.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      charge_pump_cal_result <= CP_RST;
      vco_current_cal_result <= VCUR_RST;
      vco_cap_cal_result     <= VCAP_RST;
    end else if (cal_done) begin
      if (cp_en) begin
        charge_pump_cal_result <= {meas_cp_cal[7:6],
                                   charge_pump_cal_result[5:4],
                                   meas_cp_cal[3:0]};
      end
      vco_current_cal_result <= meas_vco_current;
      vco_cap_cal_result     <= meas_vco_cap;
    end else if (wr_lane0) begin
      if (wr_addr == OFS_CP) begin
        charge_pump_cal_result <= wr_data[7:0];
      end
      if (wr_addr == OFS_VCUR) begin
        vco_current_cal_result <= wr_data[7:0];
      end
      if (wr_addr == OFS_VCAP) begin
        vco_cap_cal_result <= wr_data[7:0];
      end
    end
  end

  scp_cal_engine #(
    .FULL_26  (FULL_26),
    .FULL_24  (FULL_24),
    .SHORT_26 (SHORT_26),
    .SHORT_24 (SHORT_24)
  ) u_cal (
    .clk     (clk),
    .rst_n   (rst_n),
    .start   (cal_start),
    .abort   (cal_abort),
    .cp_en   (cp_en),
    .ref_24m (ref_24m),
    .busy    (cal_busy),
    .done    (cal_done)
  );

  // ****************************************************************
  // Radio controller.
  // ****************************************************************

  // Next state; idle strobe and power-down take precedence.
  always_comb begin
    state_next = state_reg;
    cal_start  = 1'b0;
    cal_abort  = 1'b0;
    if (stb_idle || (power_down_mode != 2'h0)) begin
      state_next = ST_IDLE;
      cal_abort  = 1'b1;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (stb_cal) begin
            state_next = ST_CAL_MAN;
            cal_start  = 1'b1;
          end else if (stb_rx || stb_tx) begin
            if (autocal == AC_ON) begin
              state_next = ST_CAL_ON;
              cal_start  = 1'b1;
            end else begin
              state_next = ST_SETTLE;
            end
          end
        end
        ST_CAL_MAN: begin
          if (cal_done) state_next = ST_IDLE;
        end
        ST_CAL_ON: begin
          if (cal_done) state_next = ST_SETTLE;
        end
        ST_SETTLE: begin
          if (settle_cnt_reg == '0) begin
            state_next = target_tx_reg ? ST_TX : ST_RX;
          end
        end
        ST_RX, ST_TX: begin
          if (synth_auto_off) begin
            if ((autocal != AC_NEVER) && (autocal != AC_ON)) begin
              state_next = ST_CAL_OFF;
              cal_start  = 1'b1;
            end else begin
              state_next = ST_IDLE;
            end
          end else if (stb_tx) begin
            state_next = ST_TX;
          end else if (stb_rx) begin
            state_next = ST_RX;
          end
        end
        ST_CAL_OFF: begin
          if (cal_done) state_next = ST_IDLE;
        end
        default: state_next = ST_IDLE;
      endcase
    end
  end

  // State register.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Destination of a turn-on, remembered from the strobe taken in idle.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      target_tx_reg <= 1'b0;
    end else if ((state_reg == ST_IDLE) && (stb_rx || stb_tx)) begin
      target_tx_reg <= stb_tx && !stb_rx;
    end
  end

  // Synthesizer turn-on time, loaded as the settle state is entered.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      settle_cnt_reg <= '0;
    end else if ((state_next == ST_SETTLE) && (state_reg != ST_SETTLE)) begin
      settle_cnt_reg <= ref_24m ? CNT_W'(TURNON_24 - 1)
                                : CNT_W'(TURNON_26 - 1);
    end else if (settle_cnt_reg != '0) begin
      settle_cnt_reg <= settle_cnt_reg - CNT_W'(1);
    end
  end

  // Status outputs, decoded from the state register and the busy flag.
  always_comb begin
    synth_on         = (state_reg != ST_IDLE);
    synth_cal_active = cal_busy;
    radio_rx_on      = (state_reg == ST_RX);
    radio_tx_on      = (state_reg == ST_TX);
    radio_idle       = (state_reg == ST_IDLE);
  end

  // ****************************************************************
  // Checks.
  // ****************************************************************
  property p_pa_level;
    @(posedge clk) disable iff (!rst_n)
    (wr_lane0 && (wr_addr == OFS_PA)) |=>
      (pa_power_setting == $past(wr_data[7:0]));
  endproperty
  a_pa_level: assert property (p_pa_level)
    else $error("Power setting not taken from the write.");

  property p_idle_force;
    @(posedge clk) disable iff (!rst_n)
    stb_idle |=> (state_reg == ST_IDLE) && !cal_busy;
  endproperty
  a_idle_force: assert property (p_idle_force)
    else $error("Idle strobe did not force idle.");

  property p_manual_cal;
    @(posedge clk) disable iff (!rst_n)
    ((state_reg == ST_IDLE) && stb_cal && !stb_idle &&
     (power_down_mode == 2'h0)) |=> (state_reg == ST_CAL_MAN) && cal_busy;
  endproperty
  a_manual_cal: assert property (p_manual_cal)
    else $error("Calibrate strobe in idle did not start calibration.");

  property p_manual_end;
    @(posedge clk) disable iff (!rst_n)
    ((state_reg == ST_CAL_MAN) && cal_done && !stb_idle) |=>
      (state_reg == ST_IDLE) &&
      (vco_cap_cal_result == $past(meas_vco_cap));
  endproperty
  a_manual_end: assert property (p_manual_end)
    else $error("Manual calibration did not end in idle with results.");

  property p_retain;
    @(posedge clk) disable iff (!rst_n)
    ((power_down_mode != 2'h0) && !wr_lane0 && !cal_done) |=>
      $stable(vco_current_cal_result) && $stable(vco_cap_cal_result) &&
      $stable(charge_pump_cal_result);
  endproperty
  a_retain: assert property (p_retain)
    else $error("Calibration results lost in power-down.");

  property p_cp_skip;
    @(posedge clk) disable iff (!rst_n)
    (cal_done && !cp_en) |=> $stable(charge_pump_cal_result);
  endproperty
  a_cp_skip: assert property (p_cp_skip)
    else $error("Charge pump result changed while disabled.");

  property p_autocal_on;
    @(posedge clk) disable iff (!rst_n)
    ((state_reg == ST_IDLE) && stb_rx && !stb_cal && !stb_idle &&
     (power_down_mode == 2'h0) && (autocal == AC_ON)) |=>
      (state_reg == ST_CAL_ON) ##1 cal_busy;
  endproperty
  a_autocal_on: assert property (p_autocal_on)
    else $error("Turn-on calibration not started.");

  property p_settle_exit;
    @(posedge clk) disable iff (!rst_n)
    ((state_reg == ST_SETTLE) && (settle_cnt_reg == '0) && !stb_idle &&
     (power_down_mode == 2'h0)) |=>
      (radio_rx_on != radio_tx_on);
  endproperty
  a_settle_exit: assert property (p_settle_exit)
    else $error("Turn-on did not reach receive or transmit.");

endmodule

// ---- src/scp_pkg.sv ----
package scp_pkg;

  // ****************************************************************
  // Clock and timing.
  // ****************************************************************
  localparam int CLK_PERIOD_NS   = 5;
  localparam int CAL_FULL_26_US  = 735;
  localparam int CAL_FULL_24_US  = 796;
  localparam int CAL_SHORT_26_US = 168;
  localparam int CAL_SHORT_24_US = 182;
  localparam int TURNON_26_US    = 75;
  localparam int TURNON_24_US    = 81;
  // Least times round up to whole clock cycles.
  localparam int CAL_FULL_26_CYC  =
    (CAL_FULL_26_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CAL_FULL_24_CYC  =
    (CAL_FULL_24_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CAL_SHORT_26_CYC =
    (CAL_SHORT_26_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CAL_SHORT_24_CYC =
    (CAL_SHORT_24_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TURNON_26_CYC    =
    (TURNON_26_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TURNON_24_CYC    =
    (TURNON_24_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W            = 18;

  // ****************************************************************
  // Register map, fields and reset values.
  // ****************************************************************
  localparam int         ADDR_W     = 8;
  localparam logic [7:0] OFS_PA     = 8'h00;
  localparam logic [7:0] OFS_CFG    = 8'h04;
  localparam logic [7:0] OFS_STROBE = 8'h08;
  localparam logic [7:0] OFS_CP     = 8'h0C;
  localparam logic [7:0] OFS_VCUR   = 8'h10;
  localparam logic [7:0] OFS_VCAP   = 8'h14;
  localparam logic [7:0] OFS_STAT   = 8'h18;
  localparam int         REF24_BIT  = 0;
  localparam int         AUTOCAL_LSB = 4;
  localparam int         CP_EN_LSB  = 4;
  localparam int         STB_CAL    = 0;
  localparam int         STB_RX     = 1;
  localparam int         STB_TX     = 2;
  localparam int         STB_IDLE   = 3;
  localparam logic [7:0] PA_RST     = 8'h00;
  localparam logic [7:0] CFG_RST    = 8'h00;
  localparam logic [7:0] CP_RST     = 8'h20;
  localparam logic [7:0] VCUR_RST   = 8'h00;
  localparam logic [7:0] VCAP_RST   = 8'h00;
  localparam logic [1:0] RESP_OKAY  = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ****************************************************************
  // Auto-calibration modes and controller states.
  // ****************************************************************
  localparam logic [1:0] AC_NEVER = 2'h0;
  localparam logic [1:0] AC_ON    = 2'h1;

  typedef enum logic [2:0] {
    ST_IDLE, ST_CAL_MAN, ST_CAL_ON, ST_SETTLE, ST_RX, ST_TX, ST_CAL_OFF
  } scp_state_t;

endpackage

// ---- src/scp_cal_engine.sv ----
`timescale 1ns/1ps
module scp_cal_engine
  import scp_pkg::*;
#(
  parameter int FULL_26  = CAL_FULL_26_CYC,
  parameter int FULL_24  = CAL_FULL_24_CYC,
  parameter int SHORT_26 = CAL_SHORT_26_CYC,
  parameter int SHORT_24 = CAL_SHORT_24_CYC
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic start,
  input  wire logic abort,
  input  wire logic cp_en,
  input  wire logic ref_24m,
  output logic      busy,
  output logic      done
);

  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] len_m1;
  logic [CNT_W-1:0] len_reg;
  logic [CNT_W-1:0] run_reg;

  // Charge-pump calibration dominates the run time when it is enabled.
  assign len_m1 = cp_en ? (ref_24m ? CNT_W'(FULL_24 - 1)
                                   : CNT_W'(FULL_26 - 1))
                        : (ref_24m ? CNT_W'(SHORT_24 - 1)
                                   : CNT_W'(SHORT_26 - 1));
  assign done   = busy && (cnt_reg == '0);

  // Down counter of the running calibration.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy    <= 1'b0;
      cnt_reg <= '0;
      len_reg <= '0;
    end else if (abort) begin
      busy <= 1'b0;
    end else if (start) begin
      busy    <= 1'b1;
      cnt_reg <= len_m1;
      len_reg <= len_m1;
    end else if (busy) begin
      busy    <= (cnt_reg != '0);
      cnt_reg <= cnt_reg - CNT_W'(1);
    end
  end

  // Cycles spent in the current run, read only by the checks.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      run_reg <= '0;
    end else if (start) begin
      run_reg <= '0;
    end else if (busy) begin
      run_reg <= run_reg + CNT_W'(1);
    end
  end

  property p_run_len;
    @(posedge clk) disable iff (!rst_n)
    done |-> (run_reg == len_reg);
  endproperty
  a_run_len: assert property (p_run_len)
    else $error("Calibration length differs from its setting.");

  property p_short_len;
    @(posedge clk) disable iff (!rst_n)
    (start && !abort && !cp_en && !ref_24m) |=>
      (len_reg == CNT_W'(SHORT_26 - 1));
  endproperty
  a_short_len: assert property (p_short_len)
    else $error("Short calibration length not selected.");

endmodule

// ---- src/scp_axil_slave.sv ----
`timescale 1ns/1ps
module scp_axil_slave
  import scp_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output logic                   wr_en,
  output logic [ADDR_W-1:0]      wr_addr,
  output logic [31:0]            wr_data,
  output logic [3:0]             wr_strb,
  input  wire logic              wr_hit,
  output logic [ADDR_W-1:0]      rd_addr,
  input  wire logic [31:0]       rd_data,
  input  wire logic              rd_hit
);

  logic aw_held;
  logic w_held;

  // Each write channel is taken once and held until the write is done.
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign wr_en         = aw_held && w_held && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_addr       = s_axi_araddr;

  // Write address and data capture, in either order.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_held      <= 1'b0;
      w_held       <= 1'b0;
      wr_addr      <= '0;
      wr_data      <= '0;
      wr_strb      <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        wr_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held  <= 1'b1;
        wr_data <= s_axi_wdata;
        wr_strb <= s_axi_wstrb;
      end
      if (wr_en) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read data is captured at the address handshake.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_data;
      s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

// ---- verification/testbench.sv ----
`timescale 1ns/1ps
module testbench
  import scp_pkg::*;
;
  logic        clk, rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_rready, synth_auto_off, s_axi_awready;
  logic        s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        synth_on, synth_cal_active, radio_rx_on, radio_tx_on;
  logic        radio_idle;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, meas_cp_cal, meas_vco_current;
  logic [7:0]  meas_vco_cap, pa_power_setting, charge_pump_cal_result;
  logic [7:0]  vco_current_cal_result, vco_cap_cal_result;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, power_down_mode;
  int          fail_count, total_checks, ncal, n0, cyc;

  // Short counts keep each calibration within a few dozen cycles.
  scp_synth_ctrl #(.FULL_26(40), .FULL_24(44), .SHORT_26(12),
    .SHORT_24(14), .TURNON_26(6), .TURNON_24(7)) dut_u (.*);

  // Clock of 5 ns period.
  initial clk = 1'b0;
  always #2.5 clk = ~clk;

  // Counts busy calibration cycles and cuts a hang short.
  always @(posedge clk) begin
    if (synth_cal_active === 1'b1) ncal <= ncal + 1;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      print_verdict();
    end
  end

  // Prints the verdict and ends the run.
  task automatic print_verdict();
    if (fail_count == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Compares one value and reports a difference.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Writes one register and checks the response code.
  task automatic wr(input logic [7:0] a, input logic [7:0] d,
                    input logic [1:0] er);
    bit pa;
    bit pw;
    pa = 1;
    pw = 1;
    s_axi_awaddr  <= a;
    s_axi_wdata   <= {24'h000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_wstrb   <= 4'h1;
    s_axi_bready  <= 1'b1;
    forever begin
      @(posedge clk);
      if (s_axi_bvalid === 1'b1) begin
        chk({30'h0, s_axi_bresp}, {30'h0, er});
        break;
      end
      if (pa && s_axi_awready) begin
        pa = 0;
        s_axi_awvalid <= 1'b0;
      end
      if (pw && s_axi_wready) begin
        pw = 0;
        s_axi_wvalid <= 1'b0;
      end
    end
  endtask

  // Reads one register and checks data and response code.
  task automatic rd(input logic [7:0] a, input logic [7:0] e,
                    input logic [1:0] er);
    bit pr;
    pr = 1;
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    forever begin
      @(posedge clk);
      if (!pr && s_axi_rvalid === 1'b1) begin
        chk(s_axi_rdata, {24'h000000, e});
        chk({30'h0, s_axi_rresp}, {30'h0, er});
        break;
      end
      if (pr && s_axi_arready) begin
        pr = 0;
        s_axi_arvalid <= 1'b0;
      end
    end
  endtask

  // Reset, then the scenario sequence.
  initial begin
    {rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = '0;
    {synth_auto_off, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {power_down_mode, meas_cp_cal, meas_vco_current, meas_vco_cap} = '0;
    {s_axi_bready, s_axi_rready, s_axi_wstrb} = '0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(OFS_PA, PA_RST, RESP_OKAY);
    rd(OFS_CP, CP_RST, RESP_OKAY);
    wr(OFS_PA, 8'hFF, RESP_OKAY);
    chk(pa_power_setting, 8'hFF);
    wr(8'h40, 8'h55, RESP_SLVERR);
    rd(8'h40, 8'h00, RESP_SLVERR);
    wr(OFS_VCUR, 8'h3C, RESP_OKAY);
    rd(OFS_VCUR, 8'h3C, RESP_OKAY);
    meas_cp_cal <= 8'hC5;
    meas_vco_current <= 8'h5A;
    meas_vco_cap <= 8'hA5;
    n0 = ncal;
    wr(OFS_STROBE, 8'h01, RESP_OKAY);
    repeat (400) if (!radio_idle) @(posedge clk);
    chk(ncal - n0, 40);
    chk(charge_pump_cal_result, 8'hE5);
    rd(OFS_VCAP, 8'hA5, RESP_OKAY);
    power_down_mode <= 2'h2;
    repeat (2) @(posedge clk);
    power_down_mode <= 2'h0;
    @(posedge clk);
    rd(OFS_VCUR, 8'h5A, RESP_OKAY);
    chk(radio_idle, 1'b1);
    wr(OFS_CP, 8'h00, RESP_OKAY);
    wr(OFS_CFG, 8'h10, RESP_OKAY);
    meas_vco_cap <= 8'h77;
    n0 = ncal;
    wr(OFS_STROBE, 8'h02, RESP_OKAY);
    repeat (400) if (!radio_rx_on) @(posedge clk);
    chk(ncal - n0, 12);
    chk(charge_pump_cal_result, 8'h00);
    chk(vco_cap_cal_result, 8'h77);
    chk(vco_current_cal_result, 8'h5A);
    wr(OFS_STROBE, 8'h08, RESP_OKAY);
    chk(radio_idle, 1'b1);
    wr(OFS_CFG, 8'h01, RESP_OKAY);
    n0 = ncal;
    wr(OFS_STROBE, 8'h01, RESP_OKAY);
    repeat (400) if (!radio_idle) @(posedge clk);
    wr(OFS_STROBE, 8'h04, RESP_OKAY);
    wr(OFS_STROBE, 8'h08, RESP_OKAY);
    chk(synth_on, 1'b0);
    chk(ncal - n0, 14);
    // Turn-off calibration after an automatic synthesizer turn-off.
    wr(OFS_CFG, 8'h20, RESP_OKAY);
    wr(OFS_STROBE, 8'h04, RESP_OKAY);
    repeat (400) if (!radio_tx_on) @(posedge clk);
    chk(radio_tx_on, 1'b1);
    n0 = ncal;
    synth_auto_off <= 1'b1;
    @(posedge clk);
    synth_auto_off <= 1'b0;
    repeat (400) if (!radio_idle) @(posedge clk);
    chk(ncal - n0, 12);
    rd(OFS_STAT, 8'h00, RESP_OKAY);
    print_verdict();
  end
endmodule
